// >>> core/csp_top.sv
// module: cascadable serial slave port with fault flags and clock output
`timescale 1ns/1ps
module csp_top (
	input  wire logic                             i_clock,
	input  wire logic                             i_rst,
	input  wire logic                             i_cs_n,
	input  wire logic                             i_sclk,
	input  wire logic                             i_din,
	input  wire logic                             i_chain_enable_in,
	input  wire logic [csp_pkg::LEN_W-1:0]        i_xfer_bytes,
	input  wire logic [csp_pkg::BYTE_BITS-1:0]    i_tx_byte,
	input  wire logic [csp_pkg::CHANNELS-1:0]     i_input_fault,
	input  wire logic [csp_pkg::CHANNELS-1:0]     i_result_overflow,
	input  wire logic                             i_crystal_osc_enable,
	input  wire logic                             i_crystal_fitted,
	output csp_pkg::csp_pin_t                     o_dout,
	output logic                                  o_chain_enable_out,
	output csp_pkg::csp_pin_t                     o_fault_n,
	output csp_pkg::csp_pin_t                     o_range_exceeded_n,
	output csp_pkg::csp_pin_t                     o_buffered_osc_out,
	output csp_pkg::csp_rx_t                      o_rx,
	output logic                                  o_tx_req,
	output logic                                  o_xfer_active,
	output logic                                  o_xfer_done
);

	// ----------------------------------------------------------------
	// pin synchronisers
	// ----------------------------------------------------------------
	csp_pkg::csp_link_t link_raw;
	csp_pkg::csp_link_t link;
	logic [csp_pkg::CHANNELS-1:0] fault_sync;

	assign link_raw.chain_enable_in = i_chain_enable_in;
	assign link_raw.din             = i_din;
	assign link_raw.sclk            = i_sclk;
	assign link_raw.cs_n            = i_cs_n;

	csp_sync #(
		.W     (csp_pkg::PIN_W),
		.RESET (csp_pkg::PIN_RESET)
	) u_link_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async (link_raw),
		.o_level (link)
	);

	csp_sync #(
		.W     (csp_pkg::CHANNELS),
		.RESET ('0)
	) u_fault_sync (
		.i_clock (i_clock),
		.i_rst   (i_rst),
		.i_async (i_input_fault),
		.o_level (fault_sync)
	);

	// ----------------------------------------------------------------
	// edge detection on filtered levels
	// ----------------------------------------------------------------
	csp_pkg::csp_link_t prev_q;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			prev_q <= csp_pkg::PIN_RESET;
		end else begin
			prev_q <= link;
		end
	end

	wire sclk_rise  = link.sclk & ~prev_q.sclk;
	wire sclk_fall  = ~link.sclk & prev_q.sclk;
	wire cs_fall    = ~link.cs_n & prev_q.cs_n;
	wire cs_low     = ~link.cs_n;
	wire chain_fall = ~link.chain_enable_in & prev_q.chain_enable_in;

	// ----------------------------------------------------------------
	// state and counters
	// ----------------------------------------------------------------
	csp_pkg::csp_state_t                 state_q;
	csp_pkg::csp_state_t                 state_d;
	logic [csp_pkg::CNT_W-1:0]           bit_cnt_q;
	logic [csp_pkg::LEN_W-1:0]           byte_cnt_q;
	logic [csp_pkg::LEN_W-1:0]           len_q;
	logic [csp_pkg::BYTE_BITS-1:0]       rx_shift_q;
	logic [csp_pkg::BYTE_BITS-1:0]       tx_shift_q;
	logic                                drive_q;
	logic                                chain_out_q;

	// ----------------------------------------------------------------
	// decode
	// ----------------------------------------------------------------
	wire in_xfer     = (state_q == csp_pkg::CSP_XFER);
	wire last_cycle  = (bit_cnt_q == csp_pkg::BIT_FIRST);
	wire bit7_next   = (bit_cnt_q == csp_pkg::BIT_LAST);
	wire [csp_pkg::LEN_W-1:0] len_eff =
		(i_xfer_bytes == csp_pkg::LEN_ZERO) ? csp_pkg::LEN_ONE : i_xfer_bytes;
	wire last_byte   = (byte_cnt_q == len_q - csp_pkg::LEN_ONE);
	wire start_cs    = cs_fall & ~link.chain_enable_in;
	wire start_chain = cs_low & sclk_rise & last_cycle
		& ~link.chain_enable_in & (state_q == csp_pkg::CSP_WAIT);
	wire byte_end    = in_xfer & sclk_fall & bit7_next;
	wire xfer_end    = byte_end & last_byte;
	wire load_tx     = start_cs | start_chain
		| (in_xfer & sclk_rise & last_cycle);
	wire [csp_pkg::BYTE_BITS-1:0] rx_next =
		{rx_shift_q[csp_pkg::BYTE_BITS-2:0], link.din};

	// ----------------------------------------------------------------
	// next state
	// ----------------------------------------------------------------
	always_comb begin
		state_d = state_q;
		unique case (state_q)
			csp_pkg::CSP_IDLE: begin
				if (start_cs) begin
					state_d = csp_pkg::CSP_XFER;
				end else if (cs_fall) begin
					state_d = csp_pkg::CSP_WAIT;
				end
			end
			csp_pkg::CSP_WAIT: begin
				if (start_chain) begin
					state_d = csp_pkg::CSP_XFER;
				end
			end
			csp_pkg::CSP_XFER: begin
				if (xfer_end) begin
					state_d = csp_pkg::CSP_DONE;
				end
			end
			csp_pkg::CSP_DONE: begin
				state_d = csp_pkg::CSP_DONE;
			end
		endcase
		if (~cs_low && !cs_fall) begin
			state_d = csp_pkg::CSP_IDLE;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			state_q <= csp_pkg::CSP_IDLE;
		end else begin
			state_q <= state_d;
		end
	end

	// ----------------------------------------------------------------
	// bit counter framed from select falling, byte counter from transfer start (select or chain)
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst || cs_fall || !cs_low) begin
			bit_cnt_q <= csp_pkg::BIT_FIRST;
		end else if (sclk_fall) begin
			bit_cnt_q <= bit_cnt_q + 3'h1;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			byte_cnt_q <= csp_pkg::LEN_ZERO;
			len_q      <= csp_pkg::LEN_ONE;
		end else if (start_cs || start_chain) begin
			byte_cnt_q <= csp_pkg::LEN_ZERO;
			len_q      <= len_eff;
		end else if (byte_end) begin
			byte_cnt_q <= byte_cnt_q + csp_pkg::LEN_ONE;
		end
	end

	// ----------------------------------------------------------------
	// receive: capture on falling edges only while transferring
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			rx_shift_q <= csp_pkg::BYTE_ZERO;
		end else if (in_xfer && sclk_fall && cs_low) begin
			rx_shift_q <= rx_next;
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_rx <= '0;
		end else begin
			o_rx.valid <= byte_end;
			if (byte_end) begin
				o_rx.data <= rx_next;
			end
		end
	end

	// ----------------------------------------------------------------
	// transmit: launch on rising edges, first bit at select fall, or at the chain start after the chain-fall driver enable
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			tx_shift_q <= csp_pkg::BYTE_ZERO;
			o_dout.out <= 1'b0;
		end else if (load_tx) begin
			o_dout.out <= i_tx_byte[csp_pkg::BYTE_BITS-1];
			tx_shift_q <= {i_tx_byte[csp_pkg::BYTE_BITS-2:0], 1'b0};
		end else if (in_xfer && sclk_rise) begin
			o_dout.out <= tx_shift_q[csp_pkg::BYTE_BITS-1];
			tx_shift_q <= {tx_shift_q[csp_pkg::BYTE_BITS-2:0], 1'b0};
		end
	end

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_tx_req <= 1'b0;
		end else begin
			o_tx_req <= load_tx;
		end
	end

	// ----------------------------------------------------------------
	// data out driver enable
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst || !cs_low) begin
			drive_q <= 1'b0;
		end else if (xfer_end) begin
			drive_q <= 1'b0;
		end else if (start_cs) begin
			drive_q <= 1'b1;
		end else if (chain_fall && state_q == csp_pkg::CSP_WAIT) begin
			drive_q <= 1'b1;
		end else if (start_chain) begin
			drive_q <= 1'b1;
		end
	end

	wire dout_drive = drive_q & cs_low & ~xfer_end & (state_d != csp_pkg::CSP_DONE);

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_dout.oe_n <= 1'b1;
		end else begin
			o_dout.oe_n <= ~(dout_drive | (start_cs & cs_low));
		end
	end

	// ----------------------------------------------------------------
	// chain output toward the next device
	// ----------------------------------------------------------------
	wire chain_low_set = in_xfer & sclk_rise & bit7_next & last_byte;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			chain_out_q <= 1'b1;
		end else if (sclk_rise) begin
			chain_out_q <= ~chain_low_set;
		end
	end

	assign o_chain_enable_out = chain_out_q;

	// ----------------------------------------------------------------
	// status to the device core
	// ----------------------------------------------------------------
	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_xfer_active <= 1'b0;
			o_xfer_done   <= 1'b0;
		end else begin
			o_xfer_active <= (state_d == csp_pkg::CSP_XFER);
			o_xfer_done   <= xfer_end;
		end
	end

	// ----------------------------------------------------------------
	// open-drain flags, driven low when asserted
	// ----------------------------------------------------------------
	wire fault_any = |fault_sync;
	wire over_any  = |i_result_overflow;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_fault_n          <= '{out: 1'b0, oe_n: 1'b1};
			o_range_exceeded_n <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			o_fault_n.out           <= 1'b0;
			o_fault_n.oe_n          <= ~fault_any;
			o_range_exceeded_n.out  <= 1'b0;
			o_range_exceeded_n.oe_n <= ~(over_any | fault_any);
		end
	end

	// ----------------------------------------------------------------
	// buffered oscillator output, half core rate from a toggle divider
	// ----------------------------------------------------------------
	wire osc_on = i_crystal_osc_enable & i_crystal_fitted;

	always_ff @(posedge i_clock) begin
		if (i_rst) begin
			o_buffered_osc_out <= '{out: 1'b0, oe_n: 1'b1};
		end else begin
			o_buffered_osc_out.out  <= osc_on & ~o_buffered_osc_out.out;
			o_buffered_osc_out.oe_n <= ~osc_on;
		end
	end

endmodule

// >>> core/csp_pkg.sv
// package: constants, states and carriers of the cascade serial port
package csp_pkg;

	// ----------------------------------------------------------------
	// framing and widths
	// ----------------------------------------------------------------
	localparam int unsigned SYNC_STAGES = 3;
	localparam int unsigned BYTE_BITS   = 8;
	localparam int unsigned CNT_W       = 3;
	localparam int unsigned LEN_W       = 8;
	localparam int unsigned CHANNELS    = 4;
	localparam int unsigned PIN_W       = 4;

	// ----------------------------------------------------------------
	// counts and reset values
	// ----------------------------------------------------------------
	localparam logic [CNT_W-1:0] BIT_LAST     = 3'h7;
	localparam logic [CNT_W-1:0] BIT_FIRST    = 3'h0;
	localparam logic [LEN_W-1:0] LEN_ONE      = 8'h01;
	localparam logic [LEN_W-1:0] LEN_ZERO     = 8'h00;
	localparam logic [BYTE_BITS-1:0] BYTE_ZERO = 8'h00;
	// pin order in the synchroniser: chain_in, din, sclk, cs_n
	localparam logic [PIN_W-1:0] PIN_RESET    = 4'hb;

	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		CSP_IDLE = 2'h0,
		CSP_WAIT = 2'h1,
		CSP_XFER = 2'h3,
		CSP_DONE = 2'h2
	} csp_state_t;

	typedef struct packed {
		logic chain_enable_in;
		logic din;
		logic sclk;
		logic cs_n;
	} csp_link_t;

	typedef struct packed {
		logic [BYTE_BITS-1:0] data;
		logic                 valid;
	} csp_rx_t;

	typedef struct packed {
		logic out;
		logic oe_n;
	} csp_pin_t;

endpackage

// >>> core/csp_sync.sv
// module: three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module csp_sync #(
	parameter int unsigned               W     = 4,
	parameter logic        [W-1:0]       RESET = '0
) (
	input  wire logic         i_clock,
	input  wire logic         i_rst,
	input  wire logic [W-1:0] i_async,
	output logic      [W-1:0] o_level
);

	// ----------------------------------------------------------------
	// per bit: three stage flops and a level flop, level moves once stages two and three agree
	// ----------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < W; g++) begin : g_bit
			logic s1_q;
			logic s2_q;
			logic s3_q;
			logic lvl_q;
			always_ff @(posedge i_clock) begin
				if (i_rst) begin
					s1_q  <= RESET[g];
					s2_q  <= RESET[g];
					s3_q  <= RESET[g];
					lvl_q <= RESET[g];
				end else begin
					s1_q <= i_async[g];
					s2_q <= s1_q;
					s3_q <= s2_q;
					if (s2_q == s3_q) begin
						lvl_q <= s3_q;
					end
				end
			end
			assign o_level[g] = lvl_q;
		end
	endgenerate

endmodule

// >>> tb/csp_monitor.sv
// checker of the cascade serial port pins and flags
`timescale 1ns/1ps
module csp_monitor (
	input wire logic              i_clock,
	input wire logic              i_rst,
	input wire logic              i_cs_n,
	input wire logic              i_sclk,
	input wire logic              i_din,
	input wire logic              i_chain_enable_in,
	input wire logic [7:0]        i_xfer_bytes,
	input wire logic [7:0]        i_tx_byte,
	input wire logic [3:0]        i_input_fault,
	input wire logic [3:0]        i_result_overflow,
	input wire logic              i_crystal_osc_enable,
	input wire logic              i_crystal_fitted,
	input wire csp_pkg::csp_pin_t o_dout,
	input wire logic              o_chain_enable_out,
	input wire csp_pkg::csp_pin_t o_fault_n,
	input wire csp_pkg::csp_pin_t o_range_exceeded_n,
	input wire csp_pkg::csp_pin_t o_buffered_osc_out,
	input wire csp_pkg::csp_rx_t  o_rx,
	input wire logic              o_tx_req,
	input wire logic              o_xfer_active,
	input wire logic              o_xfer_done
);
	default clocking @(posedge i_clock); endclocking
	default disable iff (i_rst);
	// ----------
	// assertions
	// ----------
	a_cs_high_float: assert property (i_cs_n [*7] |-> o_dout.oe_n)
		else $error("dout driven while select high");
	a_done_release: assert property (o_xfer_done |-> ##[0:2] o_dout.oe_n)
		else $error("dout not released after last byte");
	a_rx_on_fall: assert property (o_rx.valid |-> !$past(i_sclk, 3))
		else $error("byte taken outside serial clock low phase");
	a_chain_after_rise: assert property ($changed(o_chain_enable_out) |-> $past(i_sclk, 3))
		else $error("chain output moved without serial clock rise");
	a_chain_one_cycle: assert property ($fell(o_chain_enable_out) |->
		!o_chain_enable_out [*8] ##[1:8] o_chain_enable_out)
		else $error("chain output low time wrong");
	a_fault_follow: assert property ($stable(i_input_fault) [*7] |->
		o_fault_n.oe_n == (i_input_fault == 4'h0))
		else $error("fault flag does not follow faults");
	a_flags_drain: assert property (!o_fault_n.out && !o_range_exceeded_n.out)
		else $error("flag pin driven high");
	a_ovf_set: assert property ((|i_result_overflow) [*2] |-> !o_range_exceeded_n.oe_n)
		else $error("overflow flag missed");
	a_ovf_on_fault: assert property (!o_fault_n.oe_n [*2] |-> !o_range_exceeded_n.oe_n)
		else $error("overflow flag not low on fault");
	a_ovf_clear: assert property ((i_result_overflow == 4'h0 && o_fault_n.oe_n) [*3]
		|-> o_range_exceeded_n.oe_n)
		else $error("overflow flag stuck low");
	a_osc_off: assert property (!i_crystal_osc_enable [*2] |-> o_buffered_osc_out.oe_n)
		else $error("clock output driven while disabled");
	a_osc_runs: assert property ((i_crystal_osc_enable && i_crystal_fitted) [*3] |->
		!o_buffered_osc_out.oe_n && $changed(o_buffered_osc_out.out))
		else $error("clock output not running");
	c_done: cover property (o_xfer_done);
	c_chain: cover property ($fell(o_chain_enable_out));
	c_rx: cover property (o_rx.valid);
endmodule

bind csp_top csp_monitor u_mon (.i_clock, .i_rst, .i_cs_n, .i_sclk, .i_din, .i_chain_enable_in,
	.i_xfer_bytes, .i_tx_byte, .i_input_fault, .i_result_overflow, .i_crystal_osc_enable,
	.i_crystal_fitted, .o_dout, .o_chain_enable_out, .o_fault_n, .o_range_exceeded_n,
	.o_buffered_osc_out, .o_rx, .o_tx_req, .o_xfer_active, .o_xfer_done);

// >>> tb/csp_host_model.sv
// host serial controller model driving the link pins
`timescale 1ns/1ps
module csp_host_model (
	input  wire logic i_dout,
	output logic      o_cs_n,
	output logic      o_sclk,
	output logic      o_din,
	output logic      o_chain_enable_in
);
	localparam time HALF = 32ns;
	initial begin
		o_cs_n = 1'b1;
		o_sclk = 1'b1;
		o_din = 1'b0;
		o_chain_enable_in = 1'b0;
	end
	// ----------
	// framing
	// ----------
	task automatic begin_frame(input logic chain);
		o_chain_enable_in = chain;
		#(HALF);
		o_cs_n = 1'b0;
	endtask
	task automatic end_frame();
		#(HALF);
		o_cs_n = 1'b1;
		o_din = ~o_din;
		#(4 * HALF);
	endtask
	// one byte, clock left high at the end
	task automatic shift_byte(input logic [7:0] tx, input logic drop, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			o_din = tx[i];
			if (drop && i == 3) begin
				o_chain_enable_in = 1'b0;
			end
			#(HALF);
			o_sclk = 1'b0;
			rx[i] = i_dout;
			#(HALF);
			o_sclk = 1'b1;
		end
	endtask
endmodule

// >>> tb/testbench.sv
// self-checking bench of the cascade serial port
`timescale 1ns/1ps
module testbench;
	logic              i_clock = 1'b0;
	logic              i_rst = 1'b1;
	logic [7:0]        i_xfer_bytes = 8'h01;
	logic [7:0]        i_tx_byte = 8'h00;
	logic [3:0]        i_input_fault = 4'h0;
	logic [3:0]        i_result_overflow = 4'h0;
	logic              i_crystal_osc_enable = 1'b0;
	logic              i_crystal_fitted = 1'b0;
	logic              i_cs_n, i_sclk, i_din, i_chain_enable_in;
	logic              o_chain_enable_out, o_tx_req, o_xfer_active, o_xfer_done;
	wire               dout_pin;
	csp_pkg::csp_pin_t o_dout, o_fault_n, o_range_exceeded_n, o_buffered_osc_out;
	csp_pkg::csp_rx_t  o_rx;
	logic [7:0]        tx_q[$];
	logic [7:0]        rx_q[$];
	logic [7:0]        r;
	int                n_mismatch = 0;
	int                n_compared = 0;
	int                n_drive, n_chain, n_done;

	always #2.5 i_clock = ~i_clock;
	assign dout_pin = o_dout.oe_n ? 1'bz : o_dout.out;
	csp_top u_dut (.i_clock, .i_rst, .i_cs_n, .i_sclk, .i_din, .i_chain_enable_in,
		.i_xfer_bytes, .i_tx_byte, .i_input_fault, .i_result_overflow, .i_crystal_osc_enable,
		.i_crystal_fitted, .o_dout, .o_chain_enable_out, .o_fault_n, .o_range_exceeded_n,
		.o_buffered_osc_out, .o_rx, .o_tx_req, .o_xfer_active, .o_xfer_done);
	csp_host_model u_host (.i_dout(dout_pin), .o_cs_n(i_cs_n), .o_sclk(i_sclk), .o_din(i_din),
		.o_chain_enable_in(i_chain_enable_in));

	always @(posedge i_clock) begin
		if (o_tx_req && tx_q.size() > 0) begin
			i_tx_byte <= tx_q.pop_front();
		end
		if (o_rx.valid) begin
			rx_q.push_back(o_rx.data);
		end
		n_drive += int'(o_dout.oe_n === 1'b0);
		n_chain += int'(o_chain_enable_out === 1'b0);
		n_done += int'(o_xfer_done === 1'b1);
	end
	// ----------
	// helpers
	// ----------
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		n_compared++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("Error %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic clear();
		rx_q.delete();
		n_drive = 0;
		n_chain = 0;
		n_done = 0;
	endtask
	task automatic stop_test();
		$display("compared %0d mismatches %0d", n_compared, n_mismatch);
		if (n_mismatch == 0 && n_compared > 0) begin
			$display("RESULT: PASS");
		end else begin
			$display("RESULT: FAIL");
		end
		$finish;
	endtask
	// ----------
	// scenarios
	// ----------
	task automatic t_idle();
		clear();
		u_host.shift_byte(8'hff, 1'b0, r);
		check("idle drive", 8'(n_drive), 8'h00);
		check("idle rx", 8'(rx_q.size()), 8'h00);
		$display("test idle done");
	endtask
	task automatic t_direct();
		clear();
		tx_q = '{8'h3c};
		@(posedge i_clock);
		i_tx_byte <= 8'ha5;
		i_xfer_bytes <= 8'h02;
		u_host.begin_frame(1'b0);
		u_host.shift_byte(8'h96, 1'b0, r);
		check("dout byte0", r, 8'ha5);
		check("active", 8'(o_xfer_active), 8'h01);
		u_host.shift_byte(8'h5a, 1'b0, r);
		check("dout byte1", r, 8'h3c);
		n_drive = 0;
		u_host.shift_byte(8'hc3, 1'b0, r);
		check("drive after done", 8'(n_drive), 8'h00);
		u_host.end_frame();
		check("idle active", 8'(o_xfer_active), 8'h00);
		check("rx count", 8'(rx_q.size()), 8'h02);
		check("rx byte0", rx_q[0], 8'h96);
		check("rx byte1", rx_q[1], 8'h5a);
		check("done count", 8'(n_done), 8'h01);
		check("chain low", 8'(n_chain inside {[11:14]}), 8'h01);
		$display("test direct done");
	endtask
	task automatic t_cascade();
		clear();
		@(posedge i_clock);
		i_tx_byte <= 8'h69;
		i_xfer_bytes <= 8'h01;
		u_host.begin_frame(1'b1);
		u_host.shift_byte(8'h11, 1'b0, r);
		check("wait drive", 8'(n_drive), 8'h00);
		u_host.shift_byte(8'h22, 1'b1, r);
		check("chain fall drive", 8'(n_drive > 0), 8'h01);
		u_host.shift_byte(8'he7, 1'b0, r);
		check("cascade dout", r, 8'h69);
		u_host.shift_byte(8'h44, 1'b0, r);
		u_host.end_frame();
		check("cascade rx count", 8'(rx_q.size()), 8'h01);
		check("cascade rx byte", rx_q[0], 8'he7);
		$display("test cascade done");
	endtask
	task automatic t_flags();
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clock);
			i_input_fault <= k[0] ? 4'h2 : 4'h0;
			i_result_overflow <= k[1] ? 4'h8 : 4'h0;
			repeat (8) @(posedge i_clock);
			#1;
			check("fault flag", 8'(o_fault_n.oe_n), 8'(!k[0]));
			check("overflow flag", 8'(o_range_exceeded_n.oe_n), 8'(!(k[0] | k[1])));
		end
		for (int k = 0; k < 4; k++) begin
			@(posedge i_clock);
			i_crystal_osc_enable <= k[1];
			i_crystal_fitted <= k[0];
			repeat (4) @(posedge i_clock);
			#1;
			r[0] = o_buffered_osc_out.out;
			check("osc float", 8'(o_buffered_osc_out.oe_n), 8'(!(k[1] & k[0])));
			@(posedge i_clock);
			#1;
			if (k == 3) begin
				check("osc toggle", 8'(o_buffered_osc_out.out), 8'(!r[0]));
			end
		end
		$display("test flags done");
	endtask

	initial begin
		repeat (2) @(posedge i_clock);
		i_rst <= 1'b0;
		repeat (4) @(posedge i_clock);
		t_idle();
		t_direct();
		t_cascade();
		t_flags();
		stop_test();
	end
endmodule
